// [hw/rcsi_reset_cause.sv]
/*
 * Reset-cause bookkeeping: updates the cause and stack error flags per event,
 * picks the restart address and reports the reset group for register reset.
 * Assumes at most one event per cycle and synchronous inputs on clk_i.
 */
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////

module rcsi_reset_cause #(
	parameter int unsigned PC_W = rcsi_pkg::PC_W
) (
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	input  wire rcsi_pkg::rcsi_event_t  event_i,
	input  wire rcsi_pkg::rcsi_pmode_t  pmode_i,
	input  wire logic [PC_W-1:0]        pc_i,
	input  wire logic                   stack_overflow_reset_enable_i,
	input  wire logic                   high_priority_global_irq_enable_i,
	input  wire logic                   low_priority_global_irq_enable_i,
	input  wire logic                   irq_high_pending_i,
	input  wire rcsi_pkg::rcsi_flag_wr_t flag_wr_i,
	output rcsi_pkg::rcsi_flags_t       reset_control_reg_o,
	output rcsi_pkg::rcsi_restart_t     restart_o,
	output rcsi_pkg::rcsi_group_t       reset_group_o,
	output logic                        core_reset_o
);

	////////////////////////////////////////////////////////////////////////////

	rcsi_pkg::rcsi_flags_t   flags_q;
	rcsi_pkg::rcsi_flags_t   flags_d;
	rcsi_pkg::rcsi_flags_t   sw_flags;
	rcsi_pkg::rcsi_restart_t restart_q;
	rcsi_pkg::rcsi_restart_t restart_d;
	rcsi_pkg::rcsi_group_t   group_q;
	rcsi_pkg::rcsi_group_t   group_d;
	logic                    core_reset_q;
	logic                    core_reset_d;
	logic                    low_pm;
	logic [PC_W-1:0]         next_pc;

	assign low_pm  = (pmode_i == rcsi_pkg::RCSI_PM_IDLE) || (pmode_i == rcsi_pkg::RCSI_PM_SLEEP);
	assign next_pc = pc_i + PC_W'(rcsi_pkg::PC_STEP);

	// Software writes form the base; a hardware event in the same cycle
	// overrides the bits it names, so no event is lost to a clear.
	always_comb begin
		sw_flags = flags_q;
		if (flag_wr_i.wr) begin
			sw_flags = (flags_q & ~flag_wr_i.mask) | (flag_wr_i.data & flag_wr_i.mask);
		end
	end

	always_comb begin
		flags_d      = sw_flags;
		restart_d    = '{load: 1'b0, addr: restart_q.addr};
		group_d      = rcsi_pkg::RCSI_GRP_NONE;
		core_reset_d = 1'b0;
		case (event_i)
			rcsi_pkg::RCSI_EV_POWER_ON: begin
				flags_d      = rcsi_pkg::FLAGS_POR_VALUE;
				group_d      = rcsi_pkg::RCSI_GRP_POWER;
				core_reset_d = 1'b1;
				restart_d    = '{load: 1'b1, addr: rcsi_pkg::RESET_VECTOR};
			end
			rcsi_pkg::RCSI_EV_BROWN_OUT: begin
				flags_d.reset_instr_flag_n      = 1'b1;
				flags_d.watchdog_timeout_flag_n = 1'b1;
				flags_d.powerdown_flag_n        = 1'b1;
				flags_d.brownout_flag_n         = 1'b0;
				group_d      = rcsi_pkg::RCSI_GRP_POWER;
				core_reset_d = 1'b1;
				restart_d    = '{load: 1'b1, addr: rcsi_pkg::RESET_VECTOR};
			end
			rcsi_pkg::RCSI_EV_RESET_INSTR: begin
				flags_d.reset_instr_flag_n = 1'b0;
				group_d      = rcsi_pkg::RCSI_GRP_WARM;
				core_reset_d = 1'b1;
				restart_d    = '{load: 1'b1, addr: rcsi_pkg::RESET_VECTOR};
			end
			rcsi_pkg::RCSI_EV_MASTER_CLEAR: begin
				if (pmode_i == rcsi_pkg::RCSI_PM_RUN) begin
					flags_d.watchdog_timeout_flag_n = 1'b1;
				end else if (low_pm) begin
					flags_d.watchdog_timeout_flag_n = 1'b1;
					flags_d.powerdown_flag_n        = 1'b0;
				end
				group_d      = rcsi_pkg::RCSI_GRP_WARM;
				core_reset_d = 1'b1;
				restart_d    = '{load: 1'b1, addr: rcsi_pkg::RESET_VECTOR};
			end
			rcsi_pkg::RCSI_EV_WATCHDOG_TIMEOUT: begin
				flags_d.watchdog_timeout_flag_n = 1'b0;
				if (low_pm) begin
					// Wake-up keeps the core running, so no core reset is raised.
					flags_d.powerdown_flag_n = 1'b0;
					group_d   = rcsi_pkg::RCSI_GRP_WAKE;
					restart_d = '{load: 1'b1, addr: 21'(next_pc)};
				end else begin
					group_d      = rcsi_pkg::RCSI_GRP_WARM;
					core_reset_d = 1'b1;
					restart_d    = '{load: 1'b1, addr: rcsi_pkg::RESET_VECTOR};
				end
			end
			rcsi_pkg::RCSI_EV_STACK_FULL: begin
				if (stack_overflow_reset_enable_i) begin
					flags_d.stack_full_flag = 1'b1;
					group_d      = rcsi_pkg::RCSI_GRP_WARM;
					core_reset_d = 1'b1;
					restart_d    = '{load: 1'b1, addr: rcsi_pkg::RESET_VECTOR};
				end
			end
			rcsi_pkg::RCSI_EV_STACK_UNDERFLOW: begin
				flags_d.stack_underflow_flag = 1'b1;
				if (stack_overflow_reset_enable_i) begin
					group_d      = rcsi_pkg::RCSI_GRP_WARM;
					core_reset_d = 1'b1;
					restart_d    = '{load: 1'b1, addr: rcsi_pkg::RESET_VECTOR};
				end
			end
			rcsi_pkg::RCSI_EV_IRQ_WAKE: begin
				flags_d.powerdown_flag_n = 1'b0;
				group_d = rcsi_pkg::RCSI_GRP_WAKE;
				if (irq_high_pending_i && high_priority_global_irq_enable_i) begin
					restart_d = '{load: 1'b1, addr: rcsi_pkg::HIGH_IRQ_VEC};
				end else if (!irq_high_pending_i && low_priority_global_irq_enable_i) begin
					restart_d = '{load: 1'b1, addr: rcsi_pkg::LOW_IRQ_VEC};
				end else begin
					restart_d = '{load: 1'b1, addr: 21'(next_pc)};
				end
			end
			default: begin
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////

	// The flags model power-on state: sys_rst_i stands for the power-on reset
	// and, like a RCSI_EV_POWER_ON event, forces them to FLAGS_POR_VALUE.
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			flags_q <= rcsi_pkg::FLAGS_POR_VALUE;
		end else begin
			flags_q <= flags_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			restart_q    <= '{load: 1'b1, addr: rcsi_pkg::RESET_VECTOR};
			group_q      <= rcsi_pkg::RCSI_GRP_POWER;
			core_reset_q <= 1'b1;
		end else begin
			restart_q    <= restart_d;
			group_q      <= group_d;
			core_reset_q <= core_reset_d;
		end
	end

	assign reset_control_reg_o = flags_q;
	assign restart_o           = restart_q;
	assign reset_group_o       = group_q;
	assign core_reset_o        = core_reset_q;

endmodule : rcsi_reset_cause

// [hw/rcsi_pkg.sv]
/*
 * Package for the reset-cause and restart-address block: event codes, flag layout,
 * restart addresses and reset values.
 * Assumes a single 125 MHz clock domain and a 21-bit program counter.
 */
package rcsi_pkg;

	localparam int unsigned PC_W = 21;

	// Restart addresses and the step added to pc_i for a wake-up restart.
	localparam logic [20:0] RESET_VECTOR   = 21'h000000;
	localparam logic [20:0] HIGH_IRQ_VEC   = 21'h000008;
	localparam logic [20:0] LOW_IRQ_VEC    = 21'h000018;
	localparam logic [20:0] PC_STEP        = 21'h000002;

	// Flag state after a power-on reset, in the order of rcsi_flags_t.
	localparam logic [6:0] FLAGS_POR_VALUE = 7'h70;

	// Kinds of reset and wake-up event, one per cycle.
	typedef enum logic [3:0] {
		RCSI_EV_NONE,
		RCSI_EV_POWER_ON,
		RCSI_EV_BROWN_OUT,
		RCSI_EV_RESET_INSTR,
		RCSI_EV_MASTER_CLEAR,
		RCSI_EV_WATCHDOG_TIMEOUT,
		RCSI_EV_STACK_FULL,
		RCSI_EV_STACK_UNDERFLOW,
		RCSI_EV_IRQ_WAKE
	} rcsi_event_t;

	// Power state of the core when the event arrived.
	typedef enum logic [1:0] {
		RCSI_PM_FULL,
		RCSI_PM_RUN,
		RCSI_PM_IDLE,
		RCSI_PM_SLEEP
	} rcsi_pmode_t;

	// Reset groups that select which register reset values apply.
	typedef enum logic [1:0] {
		RCSI_GRP_NONE,
		RCSI_GRP_POWER,
		RCSI_GRP_WARM,
		RCSI_GRP_WAKE
	} rcsi_group_t;

	// Cause flags; the _n flags read low when their event occurred.
	typedef struct packed {
		logic reset_instr_flag_n;
		logic watchdog_timeout_flag_n;
		logic powerdown_flag_n;
		logic power_on_flag_n;
		logic brownout_flag_n;
		logic stack_full_flag;
		logic stack_underflow_flag;
	} rcsi_flags_t;

	// Restart request toward the program counter.
	typedef struct packed {
		logic        load;
		logic [20:0] addr;
	} rcsi_restart_t;

	// Software write of the flag set (write-any with a per-bit mask).
	typedef struct packed {
		logic        wr;
		rcsi_flags_t mask;
		rcsi_flags_t data;
	} rcsi_flag_wr_t;

endpackage : rcsi_pkg

// [test/rcsi_reset_cause_properties.sv]
/* Checker for rcsi_reset_cause: how each event except power-on and brown-out moves the cause flags and pulses.
 * Assumes the bench never writes the flags in the cycle of an event. */
`timescale 1ns/1ps
module rcsi_reset_cause_checker (
	input wire logic                    clk_i,
	input wire logic                    sys_rst_i,
	input wire rcsi_pkg::rcsi_event_t   event_i,
	input wire rcsi_pkg::rcsi_pmode_t   pmode_i,
	input wire logic                    stack_overflow_reset_enable_i,
	input wire rcsi_pkg::rcsi_flags_t   reset_control_reg_o,
	input wire rcsi_pkg::rcsi_restart_t restart_o,
	input wire rcsi_pkg::rcsi_group_t   reset_group_o,
	input wire logic                    core_reset_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	logic [6:0] f;
	assign f = reset_control_reg_o;
	AST_RI: assert property (event_i == rcsi_pkg::RCSI_EV_RESET_INSTR |=> f == ($past(f) & 7'h3f)
		&& reset_group_o == rcsi_pkg::RCSI_GRP_WARM) else $error("bad reset instruction");
	AST_MCLEAR_PM: assert property (event_i == rcsi_pkg::RCSI_EV_MASTER_CLEAR && pmode_i != 2'h0 |=>
		f == (($past(f) | 7'h20) & ($past(pmode_i[1]) ? 7'h6f : 7'h7f))) else $error("bad clear");
	AST_MCLEAR_FULL: assert property (event_i == rcsi_pkg::RCSI_EV_MASTER_CLEAR && pmode_i == 2'h0 |=>
		f == $past(f) && restart_o == 22'h200000) else $error("bad clear full");
	AST_WDOG_RUN: assert property (event_i == rcsi_pkg::RCSI_EV_WATCHDOG_TIMEOUT && !pmode_i[1] |=>
		f == ($past(f) & 7'h5f) && core_reset_o) else $error("bad watchdog");
	AST_WDOG_WAKE: assert property (event_i == rcsi_pkg::RCSI_EV_WATCHDOG_TIMEOUT && pmode_i[1] |=>
		f == ($past(f) & 7'h4f) && !core_reset_o) else $error("bad watchdog wake");
	AST_STK_FULL: assert property (event_i == rcsi_pkg::RCSI_EV_STACK_FULL |=>
		f == ($past(f) | {5'h0, $past(stack_overflow_reset_enable_i), 1'b0})
		&& core_reset_o == $past(stack_overflow_reset_enable_i)) else $error("bad full");
	AST_STK_UNF: assert property (event_i == rcsi_pkg::RCSI_EV_STACK_UNDERFLOW |=>
		f == ($past(f) | 7'h01) && core_reset_o == $past(stack_overflow_reset_enable_i))
		else $error("bad underflow");
	AST_IRQ: assert property (event_i == rcsi_pkg::RCSI_EV_IRQ_WAKE |=> f == ($past(f) & 7'h6f)
		&& reset_group_o == rcsi_pkg::RCSI_GRP_WAKE && !core_reset_o) else $error("bad wake");
	cover property (event_i == rcsi_pkg::RCSI_EV_MASTER_CLEAR && pmode_i[1]);
	cover property (event_i == rcsi_pkg::RCSI_EV_IRQ_WAKE);
	cover property (reset_group_o == rcsi_pkg::RCSI_GRP_WAKE);
endmodule : rcsi_reset_cause_checker
////////////////////////////////////////////////////////////////////////////////
bind rcsi_reset_cause rcsi_reset_cause_checker chk (.*);

// [test/tb.sv]
/* Bench for rcsi_reset_cause: a sweep of every event and power mode, then random traffic.
 * Assumes the one-cycle answer of the block and a 125 MHz clock. */
`timescale 1ns/1ps
module tb;
	logic                    clk_i = 1'b0;
	logic                    sys_rst_i = 1'b1;
	rcsi_pkg::rcsi_event_t   event_i = rcsi_pkg::RCSI_EV_NONE;
	rcsi_pkg::rcsi_pmode_t   pmode_i = rcsi_pkg::RCSI_PM_FULL;
	logic [20:0]             pc_i = 21'h0;
	logic [3:0]              ctl = 4'h0;
	rcsi_pkg::rcsi_flag_wr_t flag_wr_i = '0;
	rcsi_pkg::rcsi_flags_t   flags;
	rcsi_pkg::rcsi_restart_t restart;
	rcsi_pkg::rcsi_group_t   group;
	logic                    core_reset;
	logic [6:0]              exp_f = 7'h70;
	logic [15:0]             r = 16'h004f;
	int                      num_errors = 0;
	int                      n_tests = 0;
	always #4 clk_i = ~clk_i;
	rcsi_reset_cause dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .event_i(event_i),
		.pmode_i(pmode_i), .pc_i(pc_i), .stack_overflow_reset_enable_i(ctl[3]),
		.high_priority_global_irq_enable_i(ctl[1]), .low_priority_global_irq_enable_i(ctl[0]),
		.irq_high_pending_i(ctl[2]), .flag_wr_i(flag_wr_i), .reset_control_reg_o(flags),
		.restart_o(restart), .reset_group_o(group), .core_reset_o(core_reset));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr
	task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value %s expected %0h seen %0h", n, exp, seen);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_of_test
	// Control word v: [3] stack reset enable, [2] high pending, [1:0] high and low enables.
	task automatic step(input rcsi_pkg::rcsi_event_t ev, input rcsi_pkg::rcsi_pmode_t pm,
			input logic [15:0] v);
		logic        wake;
		logic        cr;
		logic [20:0] a;
		wake = ev == rcsi_pkg::RCSI_EV_IRQ_WAKE || (ev == rcsi_pkg::RCSI_EV_WATCHDOG_TIMEOUT && pm[1]);
		cr = !(ev == rcsi_pkg::RCSI_EV_NONE || wake || (ev >= 4'h6 && !v[3]));
		a = (ev == rcsi_pkg::RCSI_EV_IRQ_WAKE && (v[2] ? v[1] : v[0])) ?
			(v[2] ? 21'h8 : 21'h18) : wake ? {v[4:0], v} + 21'h2 : 21'h0;
		case (ev)
			rcsi_pkg::RCSI_EV_NONE: if (v[12]) exp_f = (exp_f & ~v[6:0]) | (v[14:8] & v[6:0]);
			rcsi_pkg::RCSI_EV_POWER_ON: exp_f = 7'h70;
			rcsi_pkg::RCSI_EV_BROWN_OUT: exp_f = (exp_f | 7'h70) & 7'h7b;
			rcsi_pkg::RCSI_EV_RESET_INSTR: exp_f[6] = 1'b0;
			rcsi_pkg::RCSI_EV_MASTER_CLEAR: exp_f = (exp_f | (pm == 2'h0 ? 7'h0 : 7'h20)) & (pm[1] ? 7'h6f : 7'h7f);
			rcsi_pkg::RCSI_EV_WATCHDOG_TIMEOUT: exp_f = exp_f & (pm[1] ? 7'h4f : 7'h5f);
			rcsi_pkg::RCSI_EV_STACK_FULL: exp_f[1] = exp_f[1] | v[3];
			rcsi_pkg::RCSI_EV_STACK_UNDERFLOW: exp_f[0] = 1'b1;
			default: exp_f[4] = 1'b0;
		endcase
		@(posedge clk_i);
		event_i <= ev;
		pmode_i <= pm;
		pc_i <= {v[4:0], v};
		ctl <= v[3:0];
		flag_wr_i <= {ev == rcsi_pkg::RCSI_EV_NONE && v[12], v[6:0], v[14:8]};
		@(posedge clk_i);
		event_i <= rcsi_pkg::RCSI_EV_NONE;
		flag_wr_i.wr <= 1'b0;
		#1;
		check("flags", flags, exp_f);
		check("core_reset", core_reset, cr);
		// A disabled underflow is no real reset, so its restart and group are left open.
		if (!(ev == rcsi_pkg::RCSI_EV_STACK_UNDERFLOW && !v[3])) begin
			check("load", restart.load, cr || wake);
			if (cr || wake) check("addr", restart.addr, a);
			check("group", group, !(cr || wake) ? 2'h0 : wake ? 2'h3 : ev < 4'h3 ? 2'h1 : 2'h2);
		end
	endtask : step
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (12) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		@(posedge clk_i);
		#1;
		check("reset flags", flags, 7'h70);
		for (int i = 0; i < 144; i++) step(rcsi_pkg::rcsi_event_t'(i % 9),
			rcsi_pkg::rcsi_pmode_t'(i / 9 % 4), {12'hffe, 4'(16'hb5e0 >> (i / 36 * 4))});
		repeat (200) begin
			r = lfsr(r);
			step(rcsi_pkg::rcsi_event_t'(r[15:12] % 9), rcsi_pkg::rcsi_pmode_t'(r[5:4]), r);
		end
		end_of_test();
	end
	initial begin
		#20000;
		num_errors++;
		end_of_test();
	end
endmodule : tb
